// ### hdl/dvrng_pkg.sv
// constants and types of the dac volume ramp and noise gate block
// assumes nothing beyond a systemverilog compiler
package dvrng_pkg;
    localparam int CHANNELS = 4;
    localparam int SAMPLE_W = 24;
    localparam int VOL_W = 8;
    localparam int LVL_W = 11;
    localparam int DLY_W = 8;
    localparam int ENV_W = 17;
    localparam int GATE_W = 14;
    localparam int FIFO_DEPTH = 32;
    // volume code 16 is 0 dB, code 0 is +6 dB, one code is 6.02/16 dB
    localparam logic [9:0] UNITY_CODE = 10'h010;
    localparam logic [9:0] CODE_MAX = 10'h0FF;
    // internal level: four levels per code, 6.02/64 dB each
    localparam int CODE_TO_LVL = 2;
    localparam logic [LVL_W-1:0] MUTE_LVL = 11'h3FD;
    localparam logic [LVL_W-1:0] RESET_LVL = 11'h040;
    localparam logic [VOL_W-1:0] VOL_DEFAULT = 8'h10;
    localparam logic [1:0] RAMP_SEL_DEFAULT = 2'h0;
    localparam logic [2:0] MIN_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] MAX_SEL_DEFAULT = 3'h7;
    localparam logic [2:0] GATE_OFF = 3'h7;
    localparam logic [2:0] GATE_DEFAULT = 3'h7;
    localparam logic SOFT_DEFAULT = 1'h0;
    // envelope timeout in base sample periods
    localparam int ENV_TIMEOUT_FS = 100000;
    localparam logic [GATE_W-1:0] GATE_RUN = 14'h2000;
    localparam int MANT_FRAC = 15;
    // 2^(-k/16) in q16, k = 0..16
    localparam logic [16:0] MANT [17] = '{
        17'h10000, 17'h0F525, 17'h0EAC1, 17'h0E0CD,
        17'h0D745, 17'h0CE25, 17'h0C567, 17'h0BD09,
        17'h0B505, 17'h0AD58, 17'h0A5FF, 17'h09EF5,
        17'h09838, 17'h091C4, 17'h08B96, 17'h085AB,
        17'h08000
    };

    typedef enum logic [0:0] {
        DVRNG_DIV_IDLE = 1'b0,
        DVRNG_DIV_RUN = 1'b1
    } dvrng_div_state_t;
endpackage

// ### hdl/dvrng_fifo.sv
// sample frame fifo with valid and ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/10ps
module dvrng_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic wr;
    logic rd;

    assign wr = wr_valid_in && wr_ready_out;
    assign rd = rd_valid_out && rd_ready_in;
    assign rd_valid_out = cnt_q != '0;
    assign rd_data_out = mem[rd_ptr_q];
    assign cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);

    always_ff @(posedge sys_clk_in) begin
        if (wr) begin
            mem[wr_ptr_q] <= wr_data_in;
        end
    end

    // ready is a flop so the source sees a clean stall
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            wr_ready_out <= 1'b0;
        end else begin
            wr_ptr_q <= wr ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= rd ? rd_ptr_q + 1'b1 : rd_ptr_q;
            cnt_q <= cnt_d;
            wr_ready_out <= cnt_d != FULL;
        end
    end
endmodule

// ### hdl/dvrng_div.sv
// serial restoring divider, one quotient bit per clock
// assumes den_in is not zero when start_in is high
`timescale 1ns/10ps
module dvrng_div #(
    parameter int NUM_W = 17,
    parameter int DEN_W = 11
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic [NUM_W-1:0] num_in,
    input wire logic [DEN_W-1:0] den_in,
    output logic done_out,
    output logic [NUM_W-1:0] quo_out
);
    localparam int CW = $clog2(NUM_W + 1);

    dvrng_pkg::dvrng_div_state_t state_q;
    logic [NUM_W-1:0] num_q;
    logic [DEN_W-1:0] den_q;
    logic [DEN_W:0] rem_q;
    logic [DEN_W:0] trial;
    logic [CW-1:0] bit_q;

    assign trial = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};

    // a new start aborts a division in flight
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_q <= dvrng_pkg::DVRNG_DIV_IDLE;
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            bit_q <= '0;
            quo_out <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            case (state_q)
                dvrng_pkg::DVRNG_DIV_IDLE: begin
                    if (start_in) begin
                        num_q <= num_in;
                        den_q <= den_in;
                        rem_q <= '0;
                        bit_q <= CW'(NUM_W);
                        state_q <= dvrng_pkg::DVRNG_DIV_RUN;
                    end
                end
                dvrng_pkg::DVRNG_DIV_RUN: begin
                    if (start_in) begin
                        num_q <= num_in;
                        den_q <= den_in;
                        rem_q <= '0;
                        bit_q <= CW'(NUM_W);
                    end else begin
                        if (trial >= {1'b0, den_q}) begin
                            rem_q <= trial - {1'b0, den_q};
                            num_q <= {num_q[NUM_W-2:0], 1'b1};
                        end else begin
                            rem_q <= trial;
                            num_q <= {num_q[NUM_W-2:0], 1'b0};
                        end
                        bit_q <= bit_q - 1'b1;
                        if (bit_q == CW'(1)) begin
                            quo_out <= {num_q[NUM_W-2:0],
                                trial >= {1'b0, den_q}};
                            done_out <= 1'b1;
                            state_q <= dvrng_pkg::DVRNG_DIV_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= dvrng_pkg::DVRNG_DIV_IDLE;
                end
            endcase
        end
    end
endmodule

// ### hdl/dvrng_top.sv
// four channel dac volume, soft ramp, envelope tracking and noise gate
// assumes one frame of four samples per base sample period arrives
// on the input stream and the modulator side drains at that rate
`timescale 1ns/10ps
module dvrng_top #(
    parameter int ENV_TIMEOUT = dvrng_pkg::ENV_TIMEOUT_FS,
    parameter int FIFO_DEPTH = dvrng_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [95:0] in_samples_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [95:0] out_samples_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    input wire logic [31:0] chan_volume_in,
    input wire logic [7:0] master_volume_in,
    input wire logic [3:0] chan_mute_in,
    input wire logic [3:0] chan_power_down_in,
    input wire logic soft_ramp_enable_in,
    input wire logic [1:0] ramp_delay_sel_in,
    input wire logic [2:0] min_delay_sel_in,
    input wire logic [2:0] max_delay_sel_in,
    input wire logic [2:0] gate_depth_select_in,
    output logic [3:0] gate_engaged_out,
    output logic [3:0] chan_muted_out,
    output logic [3:0] ramp_active_out
);
    localparam int CH = dvrng_pkg::CHANNELS;
    localparam int SW = dvrng_pkg::SAMPLE_W;
    localparam int LW = dvrng_pkg::LVL_W;
    localparam int DW = dvrng_pkg::DLY_W;
    localparam int EW = dvrng_pkg::ENV_W;
    localparam int FW = CH * SW;
    localparam logic [EW-1:0] ENV_LAST = EW'(ENV_TIMEOUT - 1);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // power of two delay in base periods
    function automatic logic [DW-1:0] sel_to_dly(input logic [2:0] sel);
        sel_to_dly = DW'(1) << sel;
    endfunction

    // upper bit mask watched by the gate
    function automatic logic [SW-1:0] gate_mask(input logic [2:0] sel);
        logic [4:0] n;
        n = 5'h00;
        case (sel)
            3'h0: n = 5'h0D;
            3'h1: n = 5'h0E;
            3'h2: n = 5'h0F;
            3'h3: n = 5'h10;
            3'h4: n = 5'h11;
            3'h5: n = 5'h12;
            3'h6: n = 5'h18;
            default: n = 5'h00;
        endcase
        gate_mask = ~({SW{1'b1}} >> n);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // settings, held at defaults throughout reset

    logic [dvrng_pkg::VOL_W-1:0] vol_q [CH];
    logic [dvrng_pkg::VOL_W-1:0] master_q;
    logic [CH-1:0] mute_q;
    logic [CH-1:0] pdn_q;
    logic soft_q;
    logic [1:0] ramp_sel_q;
    logic [2:0] min_sel_q;
    logic [2:0] max_sel_q;
    logic [2:0] gate_sel_q;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < CH; i++) begin
                vol_q[i] <= dvrng_pkg::VOL_DEFAULT;
            end
            master_q <= dvrng_pkg::VOL_DEFAULT;
            mute_q <= '0;
            pdn_q <= '0;
            soft_q <= dvrng_pkg::SOFT_DEFAULT;
            ramp_sel_q <= dvrng_pkg::RAMP_SEL_DEFAULT;
            min_sel_q <= dvrng_pkg::MIN_SEL_DEFAULT;
            max_sel_q <= dvrng_pkg::MAX_SEL_DEFAULT;
            gate_sel_q <= dvrng_pkg::GATE_DEFAULT;
        end else begin
            for (int i = 0; i < CH; i++) begin
                vol_q[i] <= chan_volume_in[i*8 +: 8];
            end
            master_q <= master_volume_in;
            mute_q <= chan_mute_in;
            pdn_q <= chan_power_down_in;
            soft_q <= soft_ramp_enable_in;
            ramp_sel_q <= ramp_delay_sel_in;
            min_sel_q <= min_delay_sel_in;
            max_sel_q <= max_delay_sel_in;
            gate_sel_q <= gate_depth_select_in;
        end
    end

    logic [DW-1:0] ramp_dly;
    logic [DW-1:0] min_dly;
    logic [DW-1:0] max_dly;
    logic [SW-1:0] mask;

    assign ramp_dly = sel_to_dly({1'b0, ramp_sel_q});
    assign min_dly = sel_to_dly(min_sel_q);
    assign max_dly = sel_to_dly(max_sel_q);
    assign mask = gate_mask(gate_sel_q);

    ////////////////////////////////////////////////////////////////////
    // input buffering and frame pacing

    logic [FW-1:0] frame;
    logic frame_valid;
    logic tick;

    // one frame taken is one base sample period
    assign tick = frame_valid && (!out_valid_out || out_ready_in);

    dvrng_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .wr_data_in(in_samples_in),
        .wr_valid_in(in_valid_in),
        .wr_ready_out(in_ready_out),
        .rd_data_out(frame),
        .rd_valid_out(frame_valid),
        .rd_ready_in(tick)
    );

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            out_valid_out <= 1'b0;
        end else if (tick) begin
            out_valid_out <= 1'b1;
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per channel volume engine

    for (genvar ch = 0; ch < CH; ch++) begin : g_ch
        logic signed [SW-1:0] smp;
        logic [9:0] sum;
        logic [9:0] code;
        logic under;
        logic muted;
        logic [LW-1:0] vol_lvl;
        logic [LW-1:0] tgt;
        logic vol_chg;
        logic div_start;
        logic div_done;
        logic [EW-1:0] quo;
        logic [LW-1:0] span;
        logic [DW-1:0] adapt;
        logic [LW-1:0] cur_q;
        logic [LW-1:0] prev_lvl_q;
        logic [LW-1:0] anchor_q;
        logic muted_q;
        logic [DW-1:0] dly_q;
        logic [DW-1:0] tmr_q;
        logic [EW-1:0] env_q;
        logic env_live_q;
        logic [dvrng_pkg::GATE_W-1:0] gcnt_q;
        logic gate_q;
        logic quiet;
        logic [3:0] k;
        logic [16:0] m_hi;
        logic [16:0] m_lo;
        logic [18:0] m_dif;
        logic [16:0] mant;
        logic signed [41:0] prod;
        logic signed [41:0] scaled;
        logic [SW-1:0] gained;

        assign smp = frame[ch*SW +: SW];

        // combined code, 0 is +6 dB
        assign sum = {2'h0, vol_q[ch]} + {2'h0, master_q};
        assign code = (sum < dvrng_pkg::UNITY_CODE) ? 10'h000 :
            sum - dvrng_pkg::UNITY_CODE;
        assign under = code > dvrng_pkg::CODE_MAX;
        assign vol_lvl = LW'(code) << dvrng_pkg::CODE_TO_LVL;
        assign muted = under || mute_q[ch] || pdn_q[ch] || gate_q;
        assign tgt = muted ? dvrng_pkg::MUTE_LVL : vol_lvl;

        // volume edits while muted only move the unmute target
        assign vol_chg = !muted && (vol_lvl != prev_lvl_q);
        assign div_start = vol_chg && env_live_q;
        assign span = (vol_lvl > anchor_q) ? vol_lvl - anchor_q :
            anchor_q - vol_lvl;

        dvrng_div #(
            .NUM_W(EW),
            .DEN_W(LW)
        ) u_div (
            .sys_clk_in(sys_clk_in),
            .rst_b_in(rst_b_in),
            .start_in(div_start),
            .num_in(env_q),
            .den_in(span),
            .done_out(div_done),
            .quo_out(quo)
        );

        // clamp; min wins if the limits cross
        always_comb begin
            adapt = (quo > EW'(max_dly)) ? max_dly : DW'(quo);
            if (adapt < min_dly) begin
                adapt = min_dly;
            end
        end

        // envelope detector and step delay
        always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
                prev_lvl_q <= dvrng_pkg::RESET_LVL;
                anchor_q <= dvrng_pkg::RESET_LVL;
                muted_q <= 1'b1;
                env_q <= '0;
                env_live_q <= 1'b0;
                dly_q <= DW'(1);
            end else begin
                prev_lvl_q <= vol_lvl;
                muted_q <= muted;
                if (vol_chg) begin
                    env_q <= '0;
                    env_live_q <= 1'b1;
                    anchor_q <= vol_lvl;
                    if (!env_live_q) begin
                        dly_q <= ramp_dly;
                    end
                end else begin
                    if (tick && env_live_q) begin
                        if (env_q >= ENV_LAST) begin
                            env_live_q <= 1'b0;
                        end else begin
                            env_q <= env_q + 1'b1;
                        end
                    end
                    if (muted != muted_q) begin
                        dly_q <= ramp_dly;
                    end else if (div_done) begin
                        dly_q <= adapt;
                    end
                end
            end
        end

        // level stepping, one internal step per delay
        always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
                cur_q <= dvrng_pkg::MUTE_LVL;
                tmr_q <= '0;
            end else if (!soft_q) begin
                cur_q <= tgt;
                tmr_q <= '0;
            end else if (tick) begin
                if (cur_q == tgt) begin
                    tmr_q <= '0;
                end else if (tmr_q >= dly_q - 1'b1) begin
                    tmr_q <= '0;
                    // linear walk between received values
                    cur_q <= (cur_q < tgt) ? cur_q + 1'b1 :
                        cur_q - 1'b1;
                end else begin
                    tmr_q <= tmr_q + 1'b1;
                end
            end
        end

        // noise gate, watches the raw input samples
        assign quiet = ((smp & mask) == mask) ||
            ((smp & mask) == '0);
        always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
                gcnt_q <= '0;
                gate_q <= 1'b0;
            end else if (gate_sel_q == dvrng_pkg::GATE_OFF) begin
                gcnt_q <= '0;
                gate_q <= 1'b0;
            end else if (tick) begin
                if (!quiet) begin
                    gcnt_q <= '0;
                    gate_q <= 1'b0;
                end else if (gcnt_q == dvrng_pkg::GATE_RUN - 1'b1) begin
                    gate_q <= 1'b1;
                end else begin
                    gcnt_q <= gcnt_q + 1'b1;
                end
            end
        end

        // gain 2^(1-level/64), mantissa interpolated over quarter codes
        assign k = cur_q[5:2];
        assign m_hi = dvrng_pkg::MANT[k];
        assign m_lo = dvrng_pkg::MANT[5'(k) + 5'h01];
        assign m_dif = 19'(m_hi - m_lo) * 19'(cur_q[1:0]);
        assign mant = m_hi - 17'(m_dif >> 2);
        assign prod = 42'(smp) * $signed({25'h0000000, mant});
        assign scaled = prod >>> (dvrng_pkg::MANT_FRAC + cur_q[9:6]);

        // level 0 is +6 dB, so a full scale input can clip
        always_comb begin
            if (cur_q >= dvrng_pkg::MUTE_LVL) begin
                gained = '0;
            end else if (scaled > 42'sh000007FFFFF) begin
                gained = 24'h7FFFFF;
            end else if (scaled < -42'sh00000800000) begin
                gained = 24'h800000;
            end else begin
                gained = scaled[SW-1:0];
            end
        end

        always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
                out_samples_out[ch*SW +: SW] <= '0;
                gate_engaged_out[ch] <= 1'b0;
                chan_muted_out[ch] <= 1'b1;
                ramp_active_out[ch] <= 1'b0;
            end else begin
                if (tick) begin
                    out_samples_out[ch*SW +: SW] <= gained;
                end
                gate_engaged_out[ch] <= gate_q;
                chan_muted_out[ch] <= cur_q >= dvrng_pkg::MUTE_LVL;
                ramp_active_out[ch] <= cur_q != tgt;
            end
        end
    end
endmodule

// ### verif/dvrng_partner.sv
// audio source and modulator sink facing the volume block
// assumes frame_in only changes while no frame is pending
`timescale 1ns/10ps
module dvrng_partner (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [95:0] frame_in,
    input wire logic [31:0] target_in,
    input wire logic stall_in,
    input wire logic in_ready_in,
    input wire logic out_valid_in,
    input wire logic [95:0] out_samples_in,
    output logic [95:0] in_samples_out = '0,
    output logic in_valid_out = 1'b0,
    output logic out_ready_out = 1'b0,
    output logic [31:0] sent_out,
    output logic [31:0] got_out,
    output logic [95:0] last_out
);
    ////////////////////////////////////////////////////////////////////
    // requests move after the falling edge and stand until taken
    always @(negedge sys_clk_in) begin
        in_valid_out <= rst_b_in && sent_out < target_in;
        // idle lines show the inverse so stale data never looks fresh
        in_samples_out <= sent_out < target_in ? frame_in : ~frame_in;
        out_ready_out <= !stall_in;
    end
    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            sent_out <= 32'h0;
            got_out <= 32'h0;
        end else begin
            if (in_valid_out && in_ready_in)
                sent_out <= sent_out + 32'h1;
            if (out_valid_in && out_ready_out) begin
                got_out <= got_out + 32'h1;
                last_out <= out_samples_in;
            end
        end
    end
endmodule

// ### verif/dvrng_properties.sv
// port checker of the volume block
// assumes binding onto dvrng_top, one clock, sync active low reset
`timescale 1ns/10ps
module dvrng_checker (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic in_ready_out,
    input wire logic [95:0] out_samples_out,
    input wire logic out_valid_out,
    input wire logic out_ready_in,
    input wire logic [31:0] chan_volume_in,
    input wire logic [7:0] master_volume_in,
    input wire logic [3:0] chan_mute_in,
    input wire logic [3:0] chan_power_down_in,
    input wire logic soft_ramp_enable_in,
    input wire logic [2:0] gate_depth_select_in,
    input wire logic [3:0] gate_engaged_out,
    input wire logic [3:0] chan_muted_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////
    a_reset_state:
    assert property (disable iff (1'b0) !rst_b_in |=> !out_valid_out &&
        !in_ready_out && chan_muted_out == 4'hF && gate_engaged_out == 4'h0)
        else $error("outputs off their reset state");
    a_ready_release:
    assert property ($rose(rst_b_in) |-> ##[1:2] in_ready_out)
        else $error("input not ready after reset");
    a_output_hold:
    assert property (out_valid_out && !out_ready_in |=>
        out_valid_out && $stable(out_samples_out)) else $error("frame lost");
    a_frame_latency:
    assert property (in_valid_in && in_ready_out && !out_valid_out |->
        ##[1:3] out_valid_out) else $error("frame not passed on");
    a_mute_jump:
    assert property ((chan_mute_in[0] && !soft_ramp_enable_in) [*5] |->
        chan_muted_out[0]) else $error("muted channel still live");
    a_pdn_jump:
    assert property ((chan_power_down_in[3] && !soft_ramp_enable_in) [*5]
        |-> chan_muted_out[3]) else $error("powered down channel live");
    a_underrange_mute:
    assert property ((chan_volume_in[15:8] == 8'hFF && !soft_ramp_enable_in
        && master_volume_in == 8'hFF) [*5] |-> chan_muted_out[1])
        else $error("underrange gain not muted");
    a_gate_off:
    assert property ((gate_depth_select_in == 3'h7) [*4] |->
        gate_engaged_out == 4'h0) else $error("gate engaged while off");
endmodule
////////////////////////////////////////////////////////////////////////
bind dvrng_top dvrng_checker u_checker (.sys_clk_in, .rst_b_in, .in_valid_in,
    .in_ready_out, .out_samples_out, .out_valid_out, .out_ready_in,
    .chan_volume_in, .master_volume_in, .chan_mute_in, .chan_power_down_in,
    .soft_ramp_enable_in, .gate_depth_select_in, .gate_engaged_out,
    .chan_muted_out);

// ### verif/dvrng_top_tb_top.sv
// self-checking bench of the volume block
// assumes dvrng_partner on the streams and the bound port checker
`timescale 1ns/10ps
module dvrng_top_tb_top;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, stall = 1'b0;
    logic soft_ramp_enable_in = 1'b0;
    logic in_valid_in, in_ready_out, out_valid_out, out_ready_in;
    logic [95:0] in_samples_in, out_samples_out, frame = '0, last;
    logic [31:0] chan_volume_in = 32'h10101010, target = '0, sent, got;
    logic [7:0] master_volume_in = 8'h10;
    logic [3:0] chan_mute_in = 4'h0, chan_power_down_in = 4'h0;
    logic [3:0] gate_engaged_out, chan_muted_out, ramp_active_out;
    logic [1:0] ramp_delay_sel_in = 2'h0;
    logic [2:0] min_delay_sel_in = 3'h0, max_delay_sel_in = 3'h7;
    logic [2:0] gate_depth_select_in = 3'h7;
    logic [23:0] q;
    int mismatches = 0, tests_run = 0, cycles = 0;
    localparam logic [95:0] UNITY = {4{24'h001000}};
    localparam logic [95:0] NOISY = {4{24'h400000}};
    logic [7:0] vch [7] = '{8'h10, 8'h08, 8'h00, 8'h10, 8'h20, 8'h00, 8'hFF};
    logic [7:0] vms [7] = '{8'h10, 8'h18, 8'h10, 8'h00, 8'h10, 8'h00, 8'hFF};
    logic [23:0] vout [7] = '{24'h001000, 24'h001000, 24'h002000,
        24'h002000, 24'h000800, 24'h002000, 24'h000000};
    ////////////////////////////////////////////////////////////////////
    dvrng_top #(.ENV_TIMEOUT(50)) dut (.sys_clk_in, .rst_b_in, .in_samples_in,
        .in_valid_in, .in_ready_out, .out_samples_out, .out_valid_out,
        .out_ready_in, .chan_volume_in, .master_volume_in, .chan_mute_in,
        .chan_power_down_in, .soft_ramp_enable_in, .ramp_delay_sel_in,
        .min_delay_sel_in, .max_delay_sel_in, .gate_depth_select_in,
        .gate_engaged_out, .chan_muted_out, .ramp_active_out);
    dvrng_partner far_end (.sys_clk_in, .rst_b_in, .frame_in(frame),
        .target_in(target), .stall_in(stall), .in_ready_in(in_ready_out),
        .out_valid_in(out_valid_out), .out_samples_in(out_samples_out),
        .in_samples_out(in_samples_in), .in_valid_out(in_valid_in),
        .out_ready_out(out_ready_in), .sent_out(sent), .got_out(got),
        .last_out(last));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [99:0] seen, input logic [99:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic drain;
        int lim;
        lim = 0;
        while (got !== target && lim < 9000) begin
            @(negedge sys_clk_in);
            lim++;
        end
        check(lim < 9000, 1'b1);
        repeat (4) @(negedge sys_clk_in);
    endtask
    // frame is set one edge before the count so it never races the source
    task automatic send(input logic [95:0] f, input int n);
        frame = f;
        @(negedge sys_clk_in);
        target = sent + 32'(n);
        drain();
    endtask
    ////////////////////////////////////////////////////////////////////
    initial forever #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk_in);
        check({in_ready_out, out_valid_out, chan_muted_out}, 6'h0F);
        rst_b_in = 1'b1;
        for (int i = 0; i < 7; i++) begin
            chan_volume_in = {4{vch[i]}};
            master_volume_in = vms[i];
            send(UNITY, 4);
            check(last, {4{vout[i]}});
        end
        check(chan_muted_out, 4'hF);
        chan_volume_in = 32'h101010FF;
        master_volume_in = 8'h10;
        send(UNITY, 4);
        check(chan_muted_out, 4'h0);
        chan_volume_in = 32'h10101010;
        chan_mute_in = 4'h5;
        send(UNITY, 4);
        check(last, {24'h001000, 24'h0, 24'h001000, 24'h0});
        chan_mute_in = 4'h0;
        chan_power_down_in = 4'hA;
        send(UNITY, 4);
        check(last, {24'h0, 24'h001000, 24'h0, 24'h001000});
        chan_power_down_in = 4'h0;
        send(UNITY, 4);
        check({chan_muted_out, last}, {4'h0, UNITY});
        soft_ramp_enable_in = 1'b1;
        for (int s = 0; s < 4; s++) begin
            ramp_delay_sel_in = 2'(s);
            min_delay_sel_in = 3'(s);
            max_delay_sel_in = 3'(s);
            chan_volume_in = 32'h20202020;
            send(UNITY, (64 << s) - 8);
            check(ramp_active_out, 4'hF);
            send(UNITY, 16);
            check({ramp_active_out, last}, {4'h0, {4{24'h000800}}});
            chan_volume_in = 32'h10101010;
            send(UNITY, (64 << s) + 8);
            check(last, UNITY);
        end
        ramp_delay_sel_in = 2'h0;
        chan_mute_in = 4'hF;
        send(UNITY, 4);
        check({chan_muted_out, ramp_active_out}, 8'h0F);
        send(UNITY, 1000);
        check({chan_muted_out, last[23:0]}, 28'hF000000);
        chan_mute_in = 4'h0;
        send(UNITY, 1000);
        check({chan_muted_out, last}, {4'h0, UNITY});
        soft_ramp_enable_in = 1'b0;
        for (int c = 0; c < 7; c++) begin
            gate_depth_select_in = 3'h7;
            send(NOISY, 1);
            gate_depth_select_in = 3'(c);
            // quiet in exactly the monitored upper bits
            q = (c == 6) ? 24'h0 : 24'h1 << (10 - c);
            send({NOISY[95:24], q}, 8191);
            check(gate_engaged_out, 4'h0);
            send({NOISY[95:24], q}, 6);
            check(gate_engaged_out, 4'h1);
            check(last, {NOISY[95:24], 24'h0});
            send(NOISY, 1);
            check(gate_engaged_out, 4'h0);
        end
        soft_ramp_enable_in = 1'b1;
        min_delay_sel_in = 3'h0;
        chan_volume_in = 32'h11111111;
        send(UNITY, 10);
        chan_volume_in = 32'h12121212;
        repeat (20) @(negedge sys_clk_in);
        send(UNITY, 6);
        check(ramp_active_out, 4'hF);
        send(UNITY, 4);
        check(ramp_active_out, 4'h0);
        stall = 1'b1;
        frame = UNITY;
        @(negedge sys_clk_in);
        target = sent + 32'd40;
        repeat (60) @(negedge sys_clk_in);
        check(in_ready_out, 1'b0);
        stall = 1'b0;
        drain();
        check({in_ready_out, out_valid_out}, 2'h2);
        print_verdict();
    end
endmodule
